/* File: hsp_defines.svh */
// Constants for the host port, strap and shared pin block
// Assumes inclusion by bare name from the block's module
`ifndef HSP_DEFINES_SVH
`define HSP_DEFINES_SVH
`define HSP_LANE_LO 2'h1
`define HSP_LANE_HI 2'h2
`define HSP_LANE_BOTH 2'h3
`define HSP_FIFO_KEEP 7'h03
`define HSP_ZERO32 32'h0000_0000
`define HSP_LO_HALF 15:0
`define HSP_HI_HALF 31:16
`define HSP_HALF_BIT 0
`endif

/* File: hsp_pkg.sv */
// Types shared by the host port, strap and shared pin block
// Assumes the defines header is on the include path
`default_nettype none
package hsp_pkg;
  typedef enum logic [2:0] {
    HSP_IDLE = 3'h1,
    HSP_READ = 3'h2,
    HSP_WRITE = 3'h4
  } hsp_state_type;
  typedef enum logic [1:0] {
    HSP_PIN_EEPROM = 2'h0,
    HSP_PIN_GPO = 2'h1,
    HSP_PIN_MON_A = 2'h2,
    HSP_PIN_MON_B = 2'h3
  } hsp_pin_mode_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic fifo;
    logic [1:0] lanes;
    logic [6:0] addr;
    logic [31:0] wdata;
  } hsp_acc_type;
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic fifo_sel;
    logic [6:0] addr;
    logic [31:0] data;
    logic ee_data;
    logic speed;
  } hsp_pins_type;
  typedef struct packed {
    logic speed100;
    logic full_duplex;
    logic autoneg;
  } hsp_link_type;
  typedef struct packed {
    logic cs;
    logic clk;
    logic dout;
    logic doe;
  } hsp_ee_ctl_type;
endpackage
`default_nettype wire

/* File: hsp_host_port.sv */
// Host port, reset straps and shared EEPROM pins of the controller
// Assumes pins arrive asynchronously and internal ports share clk_in
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defines.svh"
module hsp_host_port
  import hsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic host_select_n_in,
  input wire logic host_read_strobe_n_in,
  input wire logic host_write_strobe_n_in,
  input wire logic fifo_select_in,
  input wire logic [6:0] host_addr_in,
  input wire logic [31:0] host_data_in,
  output logic [31:0] host_data_out,
  output logic host_data_hi_oe_out,
  output logic host_data_lo_oe_out,
  output logic host_data_hi_pulldown_en_out,
  output hsp_acc_type acc_out,
  input wire logic [31:0] acc_rdata_in,
  input wire logic low_power_in,
  output logic wake_req_out,
  input wire logic [3:0] irq_sources_in,
  input wire logic [3:0] irq_enable_in,
  input wire logic irq_active_high_in,
  input wire logic irq_open_drain_in,
  output logic irq_out,
  output logic irq_oe_out,
  input wire logic speed_strap_in,
  output logic bus_wide_out,
  output hsp_link_type link_cfg_out,
  input wire logic eeprom_data_pin_in,
  output logic eeprom_data_pin_out,
  output logic eeprom_data_pin_oe_out,
  output logic eeprom_select_pin_out,
  output logic eeprom_clock_pin_out,
  input wire hsp_pin_mode_type data_pin_mode_in,
  input wire hsp_pin_mode_type clock_pin_mode_in,
  input wire hsp_ee_ctl_type ee_ctl_in,
  output logic ee_din_out,
  input wire logic general_output_three_in,
  input wire logic general_output_four_in,
  input wire logic mii_tx_en_in,
  input wire logic mii_tx_clk_in,
  input wire logic mii_rx_dv_in,
  input wire logic mii_rx_clk_in,
  input wire logic auto_cross_en_in,
  input wire logic cross_detect_in,
  input wire logic cross_manual_in,
  output logic pair_swap_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  hsp_pins_type pins_raw;
  hsp_pins_type pins_s1_reg;
  hsp_pins_type pins_s2_reg;
  assign pins_raw = '{sel_n: host_select_n_in, rd_n: host_read_strobe_n_in,
                      wr_n: host_write_strobe_n_in, fifo_sel: fifo_select_in,
                      addr: host_addr_in, data: host_data_in,
                      ee_data: eeprom_data_pin_in, speed: speed_strap_in};
  always_ff @(posedge clk_in)
  begin
    pins_s1_reg <= pins_raw;
    pins_s2_reg <= pins_s1_reg;
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire logic rd_req;
  wire logic wr_req;
  wire logic [6:0] dec_addr;
  wire logic [1:0] dec_lanes;
  wire logic [31:0] dec_wdata;
  logic bus_wide_reg;
  assign rd_req = !pins_s2_reg.sel_n && !pins_s2_reg.rd_n;
  assign wr_req = !pins_s2_reg.sel_n && !pins_s2_reg.wr_n;
  assign dec_addr = pins_s2_reg.fifo_sel ?
                    (pins_s2_reg.addr & `HSP_FIFO_KEEP) : pins_s2_reg.addr;
  assign dec_lanes = bus_wide_reg ? `HSP_LANE_BOTH :
                     (pins_s2_reg.addr[`HSP_HALF_BIT] ? `HSP_LANE_HI : `HSP_LANE_LO);
  assign dec_wdata = bus_wide_reg ? pins_s2_reg.data :
                     {pins_s2_reg.data[`HSP_LO_HALF], pins_s2_reg.data[`HSP_LO_HALF]};

  // ----------------------------------------
  // Access state machine
  // ----------------------------------------
  hsp_state_type state_reg;
  hsp_state_type state_next;
  hsp_acc_type acc_reg;
  hsp_acc_type acc_next;
  logic [31:0] data_out_reg;
  logic [31:0] data_out_next;
  logic [31:0] wdata_reg;
  wire logic [31:0] rd_view;
  assign rd_view = (bus_wide_reg || !acc_reg.addr[`HSP_HALF_BIT]) ? acc_rdata_in :
                   {acc_rdata_in[`HSP_HI_HALF], acc_rdata_in[`HSP_HI_HALF]};
  always_comb
  begin
    state_next = state_reg;
    acc_next = acc_reg;
    acc_next.valid = 1'b0;
    data_out_next = data_out_reg;
    unique case (state_reg)
      HSP_IDLE:
      begin
        if (rd_req)
        begin
          state_next = HSP_READ;
          acc_next = '{valid: 1'b1, write: 1'b0, fifo: pins_s2_reg.fifo_sel,
                       lanes: dec_lanes, addr: dec_addr, wdata: `HSP_ZERO32};
        end
        else if (wr_req)
          state_next = HSP_WRITE;
      end
      HSP_READ:
      begin
        data_out_next = rd_view;
        if (!rd_req)
          state_next = HSP_IDLE;
      end
      HSP_WRITE:
      begin
        if (!wr_req)
        begin
          // Data is the last word latched while the strobe was still low
          state_next = HSP_IDLE;
          acc_next = '{valid: 1'b1, write: 1'b1, fifo: pins_s2_reg.fifo_sel,
                       lanes: dec_lanes, addr: dec_addr, wdata: wdata_reg};
        end
      end
    endcase
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= HSP_IDLE;
      acc_reg <= '0;
      data_out_reg <= `HSP_ZERO32;
      wdata_reg <= `HSP_ZERO32;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      data_out_reg <= data_out_next;
      wdata_reg <= (state_reg == HSP_WRITE && wr_req) ? dec_wdata : wdata_reg;
    end
  end

  // ----------------------------------------
  // Data drive, wake and straps
  // ----------------------------------------
  logic lo_oe_reg;
  logic hi_oe_reg;
  logic wake_reg;
  logic strap_done_reg;
  logic pd_en_reg;
  hsp_link_type link_reg;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      lo_oe_reg <= 1'b0;
      hi_oe_reg <= 1'b0;
      wake_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      bus_wide_reg <= 1'b0;
      pd_en_reg <= 1'b1;
      link_reg <= '0;
    end
    else
    begin
      lo_oe_reg <= (state_next == HSP_READ);
      hi_oe_reg <= (state_next == HSP_READ) && bus_wide_reg;
      wake_reg <= low_power_in && wr_req;
      strap_done_reg <= 1'b1;
      if (!strap_done_reg)
      begin
        bus_wide_reg <= pins_s2_reg.ee_data;
        pd_en_reg <= !pins_s2_reg.ee_data;
        link_reg <= '{speed100: pins_s2_reg.speed, full_duplex: 1'b0,
                      autoneg: pins_s2_reg.speed};
      end
    end
  end
  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  logic irq_reg;
  logic irq_oe_reg;
  wire logic irq_event;
  wire logic irq_level;
  assign irq_event = |(irq_sources_in & irq_enable_in);
  assign irq_level = irq_active_high_in ? irq_event : !irq_event;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_open_drain_in ? 1'b0 : irq_level;
      irq_oe_reg <= irq_open_drain_in ? !irq_level : 1'b1;
    end
  end

  // ----------------------------------------
  // Shared EEPROM pins and crossover
  // ----------------------------------------
  logic ee_do_reg;
  logic ee_oe_reg;
  logic ee_cs_reg;
  logic ee_clk_reg;
  logic ee_din_reg;
  logic swap_reg;
  wire logic ee_owned;
  wire logic data_pin_val;
  wire logic clock_pin_val;
  assign ee_owned = (data_pin_mode_in == HSP_PIN_EEPROM) &&
                    (clock_pin_mode_in == HSP_PIN_EEPROM);
  assign data_pin_val = (data_pin_mode_in == HSP_PIN_EEPROM) ? ee_ctl_in.dout :
                        (data_pin_mode_in == HSP_PIN_GPO) ? general_output_three_in :
                        (data_pin_mode_in == HSP_PIN_MON_A) ? mii_tx_en_in :
                        mii_tx_clk_in;
  assign clock_pin_val = (clock_pin_mode_in == HSP_PIN_EEPROM) ? ee_ctl_in.clk :
                         (clock_pin_mode_in == HSP_PIN_GPO) ? general_output_four_in :
                         (clock_pin_mode_in == HSP_PIN_MON_A) ? mii_rx_dv_in :
                         mii_rx_clk_in;
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ee_do_reg <= 1'b0;
      ee_oe_reg <= 1'b0;
      ee_cs_reg <= 1'b0;
      ee_clk_reg <= 1'b0;
      ee_din_reg <= 1'b0;
      swap_reg <= 1'b0;
    end
    else
    begin
      ee_do_reg <= data_pin_val;
      // Repurposed pin always drives; never an input
      ee_oe_reg <= (data_pin_mode_in == HSP_PIN_EEPROM) ? ee_ctl_in.doe : 1'b1;
      ee_cs_reg <= ee_owned && ee_ctl_in.cs;
      ee_clk_reg <= clock_pin_val;
      ee_din_reg <= pins_s2_reg.ee_data;
      swap_reg <= (auto_cross_en_in && cross_detect_in) || cross_manual_in;
    end
  end

  assign host_data_out = data_out_reg;
  assign host_data_hi_oe_out = hi_oe_reg;
  assign host_data_lo_oe_out = lo_oe_reg;
  assign host_data_hi_pulldown_en_out = pd_en_reg;
  assign acc_out = acc_reg;
  assign wake_req_out = wake_reg;
  assign irq_out = irq_reg;
  assign irq_oe_out = irq_oe_reg;
  assign bus_wide_out = bus_wide_reg;
  assign link_cfg_out = link_reg;
  assign eeprom_data_pin_out = ee_do_reg;
  assign eeprom_data_pin_oe_out = ee_oe_reg;
  assign eeprom_select_pin_out = ee_cs_reg;
  assign eeprom_clock_pin_out = ee_clk_reg;
  assign ee_din_out = ee_din_reg;
  assign pair_swap_out = swap_reg;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_drive_only_read: assert property (lo_oe_reg |-> $past(rd_req))
    else $error("data driven outside selected read");
  a_hi_half_wide: assert property (hi_oe_reg |-> bus_wide_reg && lo_oe_reg)
    else $error("upper half driven in narrow mode");
  a_read_pulse: assert property (state_reg == HSP_IDLE && rd_req
    |=> acc_reg.valid && !acc_reg.write ##1 !acc_reg.valid)
    else $error("read request not issued once");
  a_write_pulse: assert property (state_reg == HSP_WRITE && !wr_req
    |=> acc_reg.valid && acc_reg.write)
    else $error("write not issued at strobe end");
  a_no_select_idle: assert property (pins_s2_reg.sel_n && state_reg == HSP_IDLE
    |=> !acc_reg.valid)
    else $error("access without chip select");
  a_fifo_addr_mask: assert property (acc_reg.valid && acc_reg.fifo
    |-> acc_reg.addr == (acc_reg.addr & `HSP_FIFO_KEEP))
    else $error("upper address used in fifo mode");
  a_wake_on_write: assert property (low_power_in && wr_req |=> wake_req_out)
    else $error("no wake on selected write");
  a_irq_push_pull: assert property (rst_n_in && !irq_open_drain_in |=> irq_oe_out)
    else $error("push-pull interrupt not driven");
  a_ee_select_off: assert property (!ee_owned |=> !eeprom_select_pin_out)
    else $error("eeprom selected while pins repurposed");
  a_straps_hold: assert property (strap_done_reg && $past(strap_done_reg)
    |-> $stable(bus_wide_reg) && $stable(link_reg))
    else $error("strap value changed after release");
  a_speed_link: assert property (link_reg.speed100 == link_reg.autoneg
    && !link_reg.full_duplex)
    else $error("default link settings wrong");
  a_pair_swap: assert property (rst_n_in && cross_manual_in |=> pair_swap_out)
    else $error("manual reversal not applied");

  c_read: cover property (state_reg == HSP_READ ##1 state_reg == HSP_IDLE);
  c_write: cover property (acc_reg.valid && acc_reg.write);
  c_fifo: cover property (acc_reg.valid && acc_reg.fifo);
  c_wake: cover property (wake_req_out);

endmodule
`default_nettype wire

/* File: hsp_host_model.sv */
// Host CPU model: asynchronous SRAM-like bus master
// Assumes the bench resolves the shared data lines into bus_in
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model
(
  input wire logic clk_in,
  input wire logic [31:0] bus_in,
  output logic sel_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic fifo_out,
  output logic [6:0] addr_out,
  output logic [31:0] data_out,
  output logic data_oe_out
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial
  begin
    sel_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    fifo_out = 1'b0;
    addr_out = 7'h00;
    data_out = 32'h0000_0000;
    data_oe_out = 1'b0;
  end
  // ----------------------------------------
  // One strobe cycle, held 8 edges, then 6 idle
  // ----------------------------------------
  task automatic access(input logic wr, input logic sel, input logic fifo,
    input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    sel_n_out <= ~sel;
    rd_n_out <= wr;
    wr_n_out <= ~wr;
    fifo_out <= fifo;
    addr_out <= a;
    data_out <= d;
    data_oe_out <= wr;
    repeat (8) @(posedge clk_in);
    q = bus_in;
    sel_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    data_oe_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the host port block
// Assumes hsp_pkg, the design and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
  import hsp_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic fifo;
    logic [6:0] addr;
    logic [31:0] data;
    logic [1:0] lanes;
    logic [6:0] eaddr;
    logic [31:0] edata;
  } hsp_row_type;
  logic clk, rst_n, hsel_n, hrd_n, hwr_n, hfifo, hoe, lp, iah, iod, spd, ee_drv;
  logic general_output_three, general_output_four, txen, txclk, rxdv, rxclk, xauto, xdet, xman, hi_oe, lo_oe, pd_en;
  logic wake, irq, irq_oe, wide, eeo, eeoe, eesel, eeprom_clock_pin, eedin, swap;
  logic [6:0] haddr;
  logic [31:0] hdata, rdata, dout, q;
  logic [15:0] pat;
  logic [3:0] isrc, ien, dtab, ctab;
  wire [31:0] bus;
  wire eepin;
  hsp_acc_type acc, got;
  hsp_link_type link;
  hsp_ee_ctl_type ectl;
  hsp_pin_mode_type dm, cm;
  int fail_count, checks_done, n_acc, n_wake, k;
  hsp_row_type rows [6] = '{
    '{1'b0, 1'b0, 7'h10, 32'h0, 2'h1, 7'h10, 32'h0000_7E18},
    '{1'b1, 1'b0, 7'h00, 32'h0000_1234, 2'h1, 7'h00, 32'h1234_1234},
    '{1'b0, 1'b0, 7'h7F, 32'h0, 2'h2, 7'h7F, 32'h0000_C3A5},
    '{1'b1, 1'b0, 7'h41, 32'hFFFF_BEEF, 2'h2, 7'h41, 32'hBEEF_BEEF},
    '{1'b0, 1'b1, 7'h25, 32'h0, 2'h2, 7'h01, 32'h0000_C3A5},
    '{1'b1, 1'b1, 7'h7E, 32'h0000_55AA, 2'h1, 7'h02, 32'h55AA_55AA}};
  // ----------------------------------------
  // Pins: released lines show a moving pattern; upper half reads zero while pulled down
  // ----------------------------------------
  assign bus[15:0] = lo_oe ? dout[15:0] : hoe ? hdata[15:0] : pat;
  assign bus[31:16] = hi_oe ? dout[31:16] : hoe ? hdata[31:16] : pd_en ? 16'h0000 : pat;
  assign eepin = eeoe ? eeo : ee_drv;
  hsp_host_model hsp_host_model_i (.clk_in(clk), .bus_in(bus), .sel_n_out(hsel_n),
    .rd_n_out(hrd_n), .wr_n_out(hwr_n), .fifo_out(hfifo), .addr_out(haddr),
    .data_out(hdata), .data_oe_out(hoe));
  hsp_host_port hsp_host_port_i (.clk_in(clk), .rst_n_in(rst_n), .host_select_n_in(hsel_n),
    .host_read_strobe_n_in(hrd_n), .host_write_strobe_n_in(hwr_n), .fifo_select_in(hfifo),
    .host_addr_in(haddr), .host_data_in(bus), .host_data_out(dout),
    .host_data_hi_oe_out(hi_oe), .host_data_lo_oe_out(lo_oe),
    .host_data_hi_pulldown_en_out(pd_en), .acc_out(acc), .acc_rdata_in(rdata),
    .low_power_in(lp), .wake_req_out(wake), .irq_sources_in(isrc), .irq_enable_in(ien),
    .irq_active_high_in(iah), .irq_open_drain_in(iod), .irq_out(irq), .irq_oe_out(irq_oe),
    .speed_strap_in(spd), .bus_wide_out(wide), .link_cfg_out(link),
    .eeprom_data_pin_in(eepin), .eeprom_data_pin_out(eeo), .eeprom_data_pin_oe_out(eeoe),
    .eeprom_select_pin_out(eesel), .eeprom_clock_pin_out(eeprom_clock_pin), .data_pin_mode_in(dm),
    .clock_pin_mode_in(cm), .ee_ctl_in(ectl), .ee_din_out(eedin),
    .general_output_three_in(general_output_three), .general_output_four_in(general_output_four), .mii_tx_en_in(txen),
    .mii_tx_clk_in(txclk), .mii_rx_dv_in(rxdv), .mii_rx_clk_in(rxclk),
    .auto_cross_en_in(xauto), .cross_detect_in(xdet), .cross_manual_in(xman),
    .pair_swap_out(swap));
  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    pat <= ~pat;
    if (acc.valid === 1'b1)
    begin
      got <= acc;
      n_acc <= n_acc + 1;
    end
    if (wake === 1'b1)
      n_wake <= n_wake + 1;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
    checks_done++;
    if (got_v !== exp_v)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic w, input logic s);
    @(posedge clk);
    ee_drv <= w;
    spd <= s;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    check({29'h0, pd_en, wide, link.speed100}, 32'h4);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    ee_drv <= ~w;
    spd <= ~s;
    repeat (3) @(posedge clk);
    check({28'h0, wide, link}, {28'h0, w, s, 1'b0, s});
    check({31'h0, pd_en}, {31'h0, ~w});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, lp, iah, iod, spd, ee_drv, general_output_three, general_output_four, txen, txclk} = '0;
    {rxdv, rxclk, xauto, xdet, xman, isrc, ien, ectl} = '0;
    dm = HSP_PIN_EEPROM;
    cm = HSP_PIN_EEPROM;
    {pat, n_acc, n_wake, fail_count, checks_done} = '0;
    rdata = 32'hC3A5_7E18;
    do_reset(1'b1, 1'b0);
    do_reset(1'b0, 1'b1);
    foreach (rows[i])
    begin
      k = n_acc;
      hsp_host_model_i.access(rows[i].wr, 1'b1, rows[i].fifo, rows[i].addr, rows[i].data, q);
      check({21'h0, got.write, got.fifo, got.lanes, got.addr}, {21'h0, rows[i].wr, rows[i].fifo, rows[i].lanes, rows[i].eaddr});
      check(32'(n_acc - k), 32'h1);
      check(rows[i].wr ? got.wdata : {16'h0, q[15:0]}, rows[i].edata);
      check({30'h0, hi_oe, lo_oe}, 32'h0);
    end
    $display("done: narrow accesses");
    lp <= 1'b1;
    k = n_acc;
    hsp_host_model_i.access(1'b1, 1'b0, 1'b0, 7'h05, 32'h0, q);
    check({n_acc[15:0], n_wake[15:0]}, {k[15:0], 16'h0});
    hsp_host_model_i.access(1'b1, 1'b1, 1'b0, 7'h05, 32'h0, q);
    check({31'h0, n_wake > 0}, 32'h1);
    lp <= 1'b0;
    $display("done: select and wake");
    for (int i = 0; i < 4; i++)
    begin
      iah <= i[0];
      iod <= i[1];
      isrc <= 4'h4;
      ien <= 4'h4;
      repeat (3) @(posedge clk);
      check({30'h0, irq, irq_oe}, {30'h0, i[1] ? {1'b0, ~i[0]} : {i[0], 1'b1}});
      ien <= 4'hB;
      repeat (3) @(posedge clk);
      check({30'h0, irq, irq_oe}, {30'h0, i[1] ? {1'b0, i[0]} : {~i[0], 1'b1}});
    end
    $display("done: interrupt");
    ee_drv <= 1'b1;
    repeat (4) @(posedge clk);
    check({30'h0, eeoe, eedin}, 32'h1);
    {general_output_three, txen, txclk, general_output_four, rxdv, rxclk} <= 6'b001_110;
    ectl <= '{cs: 1'b1, clk: 1'b0, dout: 1'b1, doe: 1'b0};
    dtab = 4'b1001;
    ctab = 4'b0110;
    for (int m = 0; m < 8; m++)
    begin
      dm <= hsp_pin_mode_type'(m < 4 ? m[1:0] : 2'h0);
      cm <= hsp_pin_mode_type'(m < 4 ? 2'h0 : m[1:0]);
      repeat (3) @(posedge clk);
      check({29'h0, eesel, eeo, eeprom_clock_pin}, {29'h0, m == 0 || m == 4, dtab[dm], ctab[cm]});
      check({31'h0, eeoe}, {31'h0, dm != HSP_PIN_EEPROM});
    end
    $display("done: shared pins");
    for (int i = 0; i < 8; i++)
    begin
      {xman, xdet, xauto} <= i[2:0];
      repeat (2) @(posedge clk);
      check({31'h0, swap}, {31'h0, (i[0] & i[1]) | i[2]});
    end
    $display("done: crossover");
    do_reset(1'b1, 1'b1);
    hsp_host_model_i.access(1'b0, 1'b1, 1'b0, 7'h22, 32'h0, q);
    check(q, rdata);
    hsp_host_model_i.access(1'b1, 1'b1, 1'b0, 7'h22, 32'h8765_4321, q);
    check({got.lanes, got.wdata[29:0]}, {2'h3, 30'h0765_4321});
    $display("done: wide bus");
    report_and_stop();
  end
endmodule
`default_nettype wire
